// File: verilog/ext_data_mem_if.sv
// Purpose: External data memory interface with mode decode and bus timing.
// Assumes: AXI4-Lite register access; one clock clk_sys at 200 MHz.
// Notes: On-chip data RAM is held here as an array.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ext_mem_regs.svh"

module ext_data_mem_if
  import ext_mem_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire move_req_t move_req,
  input wire logic move_valid,
  output logic move_ready,
  output logic move_done,
  output logic [7:0] move_rdata,
  output bus_pins_t bus_out,
  input wire logic [7:0] data_in
);

  typedef enum {
    st_idle, st_pre, st_ale_hi, st_ale_lo, st_setup, st_strobe, st_hold, st_post
  } state_t;
  logic [7:0] timing_q, config_q, page_q;
  logic [7:0] tm_cur_q, cf_cur_q, page_cur_q;
  move_req_t req_q;
  state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] onchip_ram [4096];
  logic [7:0] din_s1_q, din_s2_q, rdata_q;
  logic done_q, last_off_q, aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q, rdata_axi_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [15:0] eff_addr;
  logic go_off, accept, phase_end, strobe_on;

  // ************************************************************
  // Decode helpers
  // ************************************************************
  // Maps a bus byte address to a register select; bit 2 flags a hit.
  function automatic logic [2:0] reg_sel(input logic [11:0] a);
    logic [2:0] r;
    r = 3'h0;
    if (a[11:10] == 2'h0 && a[1:0] == 2'h0) begin
      case (a[9:2])
        `BUS_TIMING_IDX: r = 3'h4;
        `MEM_CONFIG_IDX: r = 3'h5;
        `PAGE_SELECT_IDX: r = 3'h6;
        `MOVE_STATUS_IDX: r = 3'h7;
        default: r = 3'h0;
      endcase
    end
    return r;
  endfunction
  // Picks the phase that follows, skipping empty setup and hold phases, and the latch phases when CFG_MUX_BIT is set.
  function automatic state_t after(input state_t s, input logic [7:0] tm,
                                   input logic [7:0] cf);
    state_t n;
    n = st_idle;
    case (s)
      st_pre: n = !cf[`CFG_MUX_BIT] ? st_ale_hi :
        ((tm[`SETUP_HI:`SETUP_LO] != 2'h0) ? st_setup : st_strobe);
      st_ale_hi: n = st_ale_lo;
      st_ale_lo: n = (tm[`SETUP_HI:`SETUP_LO] != 2'h0) ? st_setup : st_strobe;
      st_setup: n = st_strobe;
      st_strobe: n = (tm[`HOLD_HI:`HOLD_LO] != 2'h0) ? st_hold : st_post;
      st_hold: n = st_post;
      default: n = st_idle;
    endcase
    return n;
  endfunction

  // Cycles minus one that a phase lasts.
  function automatic logic [3:0] phase_len(input state_t s, input logic [7:0] tm,
                                           input logic [7:0] cf);
    logic [3:0] l;
    l = 4'h0;
    case (s)
      st_pre: l = `PRE_CYCLES - 4'h1;
      st_post: l = `POST_CYCLES - 4'h1;
      st_ale_hi, st_ale_lo: l = {2'h0, cf[`CFG_ALE_HI:`CFG_ALE_LO]};
      st_setup: l = {2'h0, tm[`SETUP_HI:`SETUP_LO]} - 4'h1;
      st_strobe: l = tm[`WIDTH_HI:`WIDTH_LO];
      st_hold: l = {2'h0, tm[`HOLD_HI:`HOLD_LO]} - 4'h1;
      default: l = 4'h0;
    endcase
    return l;
  endfunction

  // ************************************************************
  // Move routing
  // ************************************************************
  // Effective address and the on-chip or off-chip decision.
  always_comb begin
    eff_addr = move_req.wide ? move_req.pointer : {page_q, move_req.index};
    case (mem_mode_t'(config_q[`CFG_MODE_HI:`CFG_MODE_LO]))
      mode_internal: go_off = 1'b0;
      mode_split, mode_bank: go_off = (eff_addr >= `ONCHIP_LIMIT);
      mode_external: go_off = 1'b1;
      default: go_off = 1'b0;
    endcase
  end

  assign move_ready = (state_q == st_idle);
  assign accept = move_valid && move_ready;
  assign phase_end = (cnt_q == 4'h0);

  // Sequencer through the phases of an off-chip move.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= st_idle;
      cnt_q <= 4'h0;
    end else if (state_q == st_idle) begin
      if (accept && go_off) begin
        state_q <= st_pre;
        cnt_q <= `PRE_CYCLES - 4'h1;
      end
    end else if (phase_end) begin
      state_q <= after(state_q, tm_cur_q, cf_cur_q);
      cnt_q <= phase_len(after(state_q, tm_cur_q, cf_cur_q), tm_cur_q, cf_cur_q);
    end else begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  // Snapshot of request and settings so register writes never disturb a move.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= '0;
      tm_cur_q <= `BUS_TIMING_RST;
      cf_cur_q <= `MEM_CONFIG_RST;
      page_cur_q <= `PAGE_SELECT_RST;
      last_off_q <= 1'b0;
    end else if (accept) begin
      req_q <= move_req;
      tm_cur_q <= timing_q;
      cf_cur_q <= config_q;
      page_cur_q <= page_q;
      last_off_q <= go_off;
    end
  end

  // On-chip RAM; only reached when the move stays on-chip.
  always_ff @(posedge clk_sys) begin
    if (accept && !go_off && move_req.write) begin
      onchip_ram[eff_addr[11:0]] <= move_req.wdata;
    end
  end

  // Two-flop synchroniser on the incoming data pins.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      din_s1_q <= 8'h00;
      din_s2_q <= 8'h00;
    end else begin
      din_s1_q <= data_in;
      din_s2_q <= din_s1_q;
    end
  end

  // Read data and completion pulse back to the core.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      done_q <= (accept && !go_off) || (state_q == st_post && phase_end);
      if (accept && !go_off && !move_req.write) begin
        rdata_q <= onchip_ram[eff_addr[11:0]];
      end else if (state_q == st_strobe && phase_end && !req_q.write) begin
        rdata_q <= din_s2_q;
      end
    end
  end

  assign move_done = done_q;
  assign move_rdata = rdata_q;

  // ************************************************************
  // Pin drive
  // ************************************************************
  // Address, data, strobes and latch enable from the phase state.
  always_comb begin
    logic own, mux, addr_ph;
    own = (state_q != st_idle);
    mux = !cf_cur_q[`CFG_MUX_BIT];
    addr_ph = (state_q == st_pre) || (state_q == st_ale_hi) || (state_q == st_ale_lo);
    strobe_on = (state_q == st_strobe);
    bus_out.addr_hi = req_q.wide ? req_q.pointer[15:8] : page_cur_q;
    bus_out.addr_hi_oe = own && (req_q.wide ||
      cf_cur_q[`CFG_MODE_HI:`CFG_MODE_LO] == mode_bank);
    bus_out.addr_lo = req_q.wide ? req_q.pointer[7:0] : req_q.index;
    bus_out.addr_lo_oe = own && !mux;
    bus_out.ale = mux && (state_q == st_ale_hi);
    if (mux && addr_ph) begin
      bus_out.data = bus_out.addr_lo;
      bus_out.data_oe = 1'b1;
    end else begin
      bus_out.data = req_q.wdata;
      bus_out.data_oe = own && req_q.write && state_q != st_post;
    end
    bus_out.rd_n = !(strobe_on && !req_q.write);
    bus_out.wr_n = !(strobe_on && req_q.write);
  end

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_axi_q;
  assign s_axi_rresp = rresp_q;

  // Write channel capture, address and data in either order.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_have_q) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_have_q && w_have_q && !bvalid_q) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (reg_sel(awaddr_q) != 3'h0) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Register stores; a write needs byte lane 0.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timing_q <= `BUS_TIMING_RST;
      config_q <= `MEM_CONFIG_RST;
      page_q <= `PAGE_SELECT_RST;
    end else if (aw_have_q && w_have_q && !bvalid_q && wstrb_q[0]) begin
      case (reg_sel(awaddr_q))
        3'h4: timing_q <= wdata_q[7:0];
        3'h5: config_q <= wdata_q[7:0] & `CFG_RW_MASK;
        3'h6: page_q <= wdata_q[7:0];
        default: timing_q <= timing_q;
      endcase
    end
  end

  // Read channel; status shows busy, last routing and current mode.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_axi_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= (reg_sel(s_axi_araddr) != 3'h0) ? `RESP_OKAY : `RESP_SLVERR;
      case (reg_sel(s_axi_araddr))
        3'h4: rdata_axi_q <= {24'h0, timing_q};
        3'h5: rdata_axi_q <= {24'h0, config_q};
        3'h6: rdata_axi_q <= {24'h0, page_q};
        3'h7: rdata_axi_q <= {28'h0, config_q[`CFG_MODE_HI:`CFG_MODE_LO], last_off_q,
                              state_q != st_idle};
        default: rdata_axi_q <= 32'h0000_0000;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic [5:0] mv_cnt_q, mv_expect;
  logic [3:0] sw_cnt_q;

  // Cycle counters for whole-move and strobe-width checks.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mv_cnt_q <= 6'h00;
      sw_cnt_q <= 4'h0;
    end else begin
      mv_cnt_q <= (state_q == st_idle) ? 6'h00 : mv_cnt_q + 6'h01;
      sw_cnt_q <= strobe_on ? sw_cnt_q + 4'h1 : 4'h0;
    end
  end

  assign mv_expect = {4'h0, tm_cur_q[`SETUP_HI:`SETUP_LO]} +
    {2'h0, tm_cur_q[`WIDTH_HI:`WIDTH_LO]} + 6'h01 +
    {4'h0, tm_cur_q[`HOLD_HI:`HOLD_LO]} + `FIXED_OVERHEAD +
    (cf_cur_q[`CFG_MUX_BIT] ? 6'h00 : {3'h0, cf_cur_q[`CFG_ALE_HI:`CFG_ALE_LO], 1'b0} + 6'h02);

  sequence s_accept_on;
    accept && !go_off;
  endsequence

  a_internal_stays_on: assert property (
    s_accept_on |=> state_q == st_idle && done_q && !bus_out.data_oe)
    else $error("on-chip move touched the pins");
  a_external_all_off: assert property (
    accept && config_q[`CFG_MODE_HI:`CFG_MODE_LO] == mode_external |=> state_q == st_pre)
    else $error("external-only move did not go off-chip");
  a_move_length: assert property (
    state_q == st_post && phase_end |-> mv_cnt_q + 6'h01 == mv_expect ##1 done_q)
    else $error("off-chip move length wrong");
  a_strobe_width: assert property (
    strobe_on && phase_end |-> sw_cnt_q == tm_cur_q[`WIDTH_HI:`WIDTH_LO] ##1 !strobe_on)
    else $error("strobe width wrong");
  a_one_strobe: assert property (
    !(!bus_out.rd_n && !bus_out.wr_n))
    else $error("both strobes low");
  a_high_undriven: assert property (
    state_q != st_idle && !req_q.wide &&
    cf_cur_q[`CFG_MODE_HI:`CFG_MODE_LO] != mode_bank |-> !bus_out.addr_hi_oe)
    else $error("high address driven on 8-bit move without bank select");
  a_bank_high: assert property (
    state_q != st_idle && !req_q.wide && cf_cur_q[`CFG_MODE_HI:`CFG_MODE_LO] == mode_bank
    |-> bus_out.addr_hi_oe && bus_out.addr_hi == page_cur_q)
    else $error("bank select high address wrong");
  a_pins_released: assert property (
    state_q == st_idle |-> !bus_out.data_oe && !bus_out.addr_hi_oe && !bus_out.addr_lo_oe
    && bus_out.rd_n && bus_out.wr_n)
    else $error("pins held outside a move");
  a_read_no_drive: assert property (
    !req_q.write && (state_q == st_strobe || state_q == st_setup) |-> !bus_out.data_oe)
    else $error("data driven during read");
  a_wdata_setup: assert property (
    $rose(bus_out.wr_n) |-> $past(bus_out.data_oe, 2) && bus_out.data_oe == (state_q == st_hold))
    else $error("write data not driven around strobe");
  a_ale_phases: assert property (
    $fell(bus_out.ale) |-> state_q == st_ale_lo && bus_out.data == bus_out.addr_lo)
    else $error("latch enable fell outside address phase");

endmodule

// File: verilog/ext_mem_regs.svh
// Purpose: Register indices, field positions, reset values and cycle counts.
// Assumes: Register byte address is four times the register index.
// Notes: Definitions only.
`ifndef EXT_MEM_REGS_SVH
`define EXT_MEM_REGS_SVH

// ************************************************************
// Register indices
// ************************************************************
`define BUS_TIMING_IDX 8'ha1
`define MEM_CONFIG_IDX 8'ha3
`define PAGE_SELECT_IDX 8'haf
`define MOVE_STATUS_IDX 8'hb0

// ************************************************************
// Fields and reset values
// ************************************************************
`define SETUP_HI 7
`define SETUP_LO 6
`define WIDTH_HI 5
`define WIDTH_LO 2
`define HOLD_HI 1
`define HOLD_LO 0
`define CFG_PORT_BIT 5
`define CFG_MUX_BIT 4
`define CFG_MODE_HI 3
`define CFG_MODE_LO 2
`define CFG_ALE_HI 1
`define CFG_ALE_LO 0
`define BUS_TIMING_RST 8'hff
`define MEM_CONFIG_RST 8'h03
`define PAGE_SELECT_RST 8'h00
`define CFG_RW_MASK 8'h3f

// ************************************************************
// Memory map and fixed phase lengths
// ************************************************************
`define ONCHIP_LIMIT 16'h1000
`define PRE_CYCLES 4'h2
`define POST_CYCLES 4'h2
`define FIXED_OVERHEAD 6'h04
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: verilog/ext_mem_pkg.sv
// Purpose: Types shared by the external data memory interface.
// Assumes: Constants live in ext_mem_regs.svh.
// Notes: Pin group and move request travel as packed structs.
package ext_mem_pkg;

  // Memory mode codes.
  typedef enum logic [1:0] {
    mode_internal = 2'h0,
    mode_split = 2'h1,
    mode_bank = 2'h2,
    mode_external = 2'h3
  } mem_mode_t;

  // One external-data move from the core.
  typedef struct packed {
    logic write;
    logic wide;
    logic [7:0] index;
    logic [15:0] pointer;
    logic [7:0] wdata;
  } move_req_t;

  // Outputs towards the memory pins.
  typedef struct packed {
    logic [7:0] addr_hi;
    logic addr_hi_oe;
    logic [7:0] addr_lo;
    logic addr_lo_oe;
    logic [7:0] data;
    logic data_oe;
    logic rd_n;
    logic wr_n;
    logic ale;
  } bus_pins_t;

endpackage

// File: verif/ext_mem_model.sv
// Purpose: Behavioural external asynchronous memory on the pin group.
// Assumes: Upper address lines park high while the interface leaves them undriven.
// Notes: Prompt mode answers as soon as the address is owned, slow mode only under the strobe.
`timescale 1ns/1ps

module ext_mem_model
  import ext_mem_pkg::*;
(
  input wire logic clk_sys,
  input wire logic slow,
  input wire bus_pins_t bus_out,
  output logic [7:0] data_in,
  output logic [15:0] cur_addr
);
  // ****
  // Address latch and storage
  // ****
  logic [7:0] mem [65536];
  logic [7:0] lat_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic mux_q = 1'h0;
  logic owned;
  logic drv;

  // The interface owns the pins while any enable or strobe is active.
  assign owned = bus_out.addr_lo_oe | bus_out.addr_hi_oe | bus_out.data_oe | bus_out.ale |
                 !bus_out.rd_n | !bus_out.wr_n;

  // Undriven upper lines show the parked port level.
  assign cur_addr = {bus_out.addr_hi_oe ? bus_out.addr_hi : 8'hff,
                     mux_q ? lat_q : bus_out.addr_lo};

  // The latch follows the shared pins while the latch strobe is high.
  always @(posedge clk_sys) begin
    if (bus_out.ale) begin
      lat_q <= bus_out.data;
      mux_q <= 1'h1;
    end else if (!owned) begin
      mux_q <= 1'h0;
    end
    last_q <= data_in;
  end

  // Write data is taken while the write strobe is low.
  always @(posedge clk_sys) begin
    if (!bus_out.wr_n) begin
      mem[cur_addr] <= bus_out.data;
    end
  end

  // Read data is held up to strobe release; a released line toggles every cycle.
  assign drv = owned && !bus_out.data_oe && bus_out.wr_n && (!slow || !bus_out.rd_n);
  assign data_in = bus_out.data_oe ? bus_out.data : (drv ? mem[cur_addr] : ~last_q);
endmodule

// File: verif/testbench.sv
// Purpose: Self-checking bench for the external data memory interface.
// Assumes: Register byte addresses are four times the register index.
// Notes: Random moves in split, bank and external modes with random bus timing.
`timescale 1ns/1ps
`include "ext_mem_regs.svh"

module testbench
  import ext_mem_pkg::*;
  ;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic [11:0] awaddr = 12'h0;
  logic [11:0] araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic move_valid = 1'h0;
  logic slow = 1'h0;
  logic mon = 1'h0;
  logic seen_doe;
  logic awready, wready, bvalid, arready, rvalid, move_ready, move_done;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] move_rdata, data_in;
  logic [15:0] cur_addr, seen_addr;
  move_req_t move_req = '0;
  bus_pins_t bus_out;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_strb, n_ale;

  ext_data_mem_if dut (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .move_req(move_req),
    .move_valid(move_valid), .move_ready(move_ready), .move_done(move_done),
    .move_rdata(move_rdata), .bus_out(bus_out), .data_in(data_in));

  ext_mem_model mem (.clk_sys(clk_sys), .slow(slow), .bus_out(bus_out), .data_in(data_in),
    .cur_addr(cur_addr));

  // ****
  // Clock, timeout and pin monitor
  // ****
  // The clock toggles every 2.5 ns, half of its 5 ns period.
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // A hang is cut short after a fixed number of cycles.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // Strobe and latch cycles and the address under the strobe are recorded.
  always @(negedge clk_sys) begin
    if (mon && (!bus_out.rd_n || !bus_out.wr_n)) begin
      n_strb++;
      seen_addr = cur_addr;
      seen_doe = bus_out.data_oe;
    end
    if (mon && bus_out.ale) begin
      n_ale++;
    end
  end

  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge clk_sys);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk_sys);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end while (!tb);
    bready <= 1'h0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge clk_sys);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ta) arvalid <= 1'h0;
    end while (!tr);
    rready <= 1'h0;
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic setcfg(input logic [7:0] tm, input logic [7:0] cf, input logic [7:0] pg);
    logic [1:0] r;
    axi_wr(12'h284, {24'h0, tm}, r);
    axi_wr(12'h28c, {24'h0, cf}, r);
    axi_wr(12'h2bc, {24'h0, pg}, r);
  endtask

  // One move; n counts falling edges after acceptance up to the done pulse.
  task automatic run(input move_req_t q, input logic [7:0] tm, input logic [7:0] cf,
                     input logic [7:0] pg);
    logic acc, o;
    logic [15:0] ea;
    int n, e;
    ea = q.wide ? q.pointer : {pg, q.index};
    o = (cf[3:2] == mode_external) || (cf[3:2] != mode_internal && ea >= 16'h1000);
    e = o ? tm[7:6] + tm[5:2] + 1 + tm[1:0] + 4 + (cf[4] ? 0 : 2 * (cf[1:0] + 1)) : 0;
    @(posedge clk_sys);
    move_req <= q;
    move_valid <= 1'h1;
    do begin
      @(negedge clk_sys);
      acc = move_ready;
      @(posedge clk_sys);
    end while (!acc);
    move_valid <= 1'h0;
    n_strb = 0;
    n_ale = 0;
    mon = 1'h1;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (move_done !== 1'h1 && n < 200);
    mon = 1'h0;
    chk(n, e + 1);
    chk(n_strb, o ? tm[5:2] + 1 : 0);
    chk(n_ale, (o && !cf[4]) ? cf[1:0] + 1 : 0);
    chk({28'h0, bus_out.addr_lo_oe, bus_out.addr_hi_oe, bus_out.data_oe, bus_out.ale}, 0);
    if (o) begin
      chk(seen_addr, {(q.wide || cf[3:2] == mode_bank) ? ea[15:8] : 8'hff, ea[7:0]});
      chk(seen_doe, q.write);
    end
    if (!q.write) begin
      chk(move_rdata, q.wdata);
    end
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    move_req_t q;
    logic [7:0] tm, cf, pg;
    logic [1:0] r;
    logic s;
    void'($urandom(32'h730a3ea0));
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'h1;
    rd_chk(12'h284, 32'hff, 2'h0);
    rd_chk(12'h28c, 32'h03, 2'h0);
    rd_chk(12'h2bc, 32'h00, 2'h0);
    rd_chk(12'h100, 32'h0, 2'h2);
    axi_wr(12'h100, 32'h55, r);
    chk({30'h0, r}, 32'h2);
    axi_wr(12'h28c, 32'hff, r);
    rd_chk(12'h28c, 32'h3f, 2'h0);
    rd_chk(12'h2c0, 32'h0c, 2'h0);
    $display("test registers done");
    // Aliased on-chip accesses through both address forms.
    q = '0;
    q.write = 1'h1;
    q.wide = 1'h1;
    q.pointer = 16'h1234;
    q.wdata = 8'ha5;
    setcfg(8'h00, 8'h10, 8'h22);
    run(q, 8'h00, 8'h10, 8'h22);
    q.write = 1'h0;
    q.wide = 1'h0;
    q.index = 8'h34;
    run(q, 8'h00, 8'h10, 8'h22);
    $display("test internal done");
    for (int i = 0; i < 40; i++) begin
      q = 42'({$urandom(), $urandom()});
      q.write = 1'h1;
      if ($urandom_range(1, 0)) q.pointer[15:12] = 4'h0;
      pg = 8'($urandom);
      if ($urandom_range(1, 0)) pg[7:4] = 4'h0;
      s = 1'($urandom);
      slow <= s;
      cf = {3'($urandom), 1'($urandom), 2'($urandom_range(3, 1)), 2'($urandom)};
      tm = {2'($urandom), 4'($urandom_range(15, cf[4] ? 0 : 2)), 2'($urandom)};
      if (s) tm[5:2] = 4'h5;
      setcfg(tm, cf, pg);
      run(q, tm, cf, pg);
      q.write = 1'h0;
      run(q, tm, cf, pg);
    end
    $display("test random moves done");
    tally_and_finish();
  end
endmodule
